/* File: sfcfe_core.sv */
// Serial flash command front end: link shifter, decoder, write gating and ID output.
// Behaviour
// - Program, erase and status writes run only if received clock count is multiple of eight.
// - Program, erase and status writes are ignored while the write enable latch is clear.
// - Program and erase to an area marked protected are refused.
// - Status bits are locked only when lock bit is one and protect pin low.
// - Each opcode is captured into an eight bit instruction register before decoding.
// - Serial input is taken MSB first on rising clock edges while selected.
// - Every transaction starts with one opcode byte, then any address or data bytes.
// - Opcode 03h is normal read with four command bytes, limited to 33 MHz.
// - Opcode 0Bh is fast read with five command bytes, up to 104 MHz.
// - Opcodes 02h and 32h are single and four line page program.
// - Sector erase D7h or 20h, block erase D8h, chip erase C7h or 60h.
// - 75h or B0h suspends a running operation, 7Ah or 30h resumes it.
// - B1h programs the security area, 4Bh reads it at up to 33 MHz.
// - Opcode 90h is maker and device code read with four command bytes.
// - After 9Fh, maker code then two device codes go out MSB first on falling edges.
// - The standard identification sequence repeats while chip select stays low.
// - Pause pin low freezes the transaction, floats output and ignores serial input.
// - After ABh and three dummy bytes, device code goes out MSB first.
// - The legacy device code repeats while clocks continue with chip select low.
// - ABh alone releases power-down; only read and identification instructions are accepted during the wake delay.
// - ABh during a running program, erase or status write is ignored.
// - The write enable latch clears when a write operation completes.
// - Chip erase runs only when all four block protect bits are zero.

`timescale 1ns/1ns

module sfcfe_core #(
    parameter logic [7:0] MAKER_CODE  = 8'ha5,  // Arbitrary value.
    parameter logic [7:0] DEV_CODE1   = 8'h3c,  // Arbitrary value.
    parameter logic [7:0] DEV_CODE2   = 8'h5e,  // Arbitrary value.
    parameter logic [7:0] LEGACY_CODE = 8'h2d   // Arbitrary value.
) (
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic                spi_sck_i,
    input  wire logic                spi_cs_n_i,
    input  wire logic                spi_si_i,
    input  wire logic                spi_hold_n_i,
    input  wire logic                spi_wp_n_i,
    output logic                     spi_so_o,
    output logic                     spi_so_oe_o,
    output logic                     read_active_o,
    output logic                     read_fast_o,
    output logic                     op_start_o,
    output sfcfe_pkg::sfcfe_op_t     op_kind_o,
    output logic [23:0]              op_addr_o,
    input  wire logic                op_done_i,
    input  wire logic                area_protected_i,
    output logic                     suspend_o,
    output logic                     resume_o,
    output logic [7:0]               status_o
);
    import sfcfe_pkg::*;

    // Link domain state.
    logic                started_ff;
    logic [CNT_W-1:0]    bit_cnt_ff;
    logic [CNT_W-1:0]    nxt_bit_cnt;
    logic [31:0]         shift_ff;
    logic [7:0]          opcode_ff;
    logic [7:0]          sr_data_ff;
    logic [23:0]         addr_ff;
    logic                busy_meta_ff;
    logic                busy_s_ff;
    logic                read_active_ff;
    logic                read_fast_ff;
    logic [2:0]          out_pos_ff;
    logic [1:0]          out_byte_ff;
    logic                so_ff;
    logic                so_en_ff;
    logic                emit;
    logic [7:0]          id_byte;
    logic [1:0]          id_last;

    // System domain state.
    logic                cs_meta_ff;
    logic                cs_sync_ff;
    logic                cs_prev_ff;
    logic                wp_meta_ff;
    logic                wp_sync_ff;
    logic                cs_rise;
    sfcfe_state_t        state_ff;
    logic [7:0]          wake_cnt_ff;
    logic                wel_ff;
    logic                sr_lock_ff;
    logic                quad_ff;
    logic [3:0]          bp_ff;
    logic                op_start_ff;
    sfcfe_op_t           op_kind_ff;
    logic [23:0]         op_addr_ff;
    logic                suspend_ff;
    logic                resume_ff;
    logic                locked;
    logic                whole;
    logic                kind_ok;
    sfcfe_op_t           kind;
    logic                do_wel_set;
    logic                do_wel_clr;
    logic                do_sr_write;
    logic                do_start;
    logic                do_wake;
    logic                do_susp;
    logic                do_resume;

    // ---------------- Link clock domain ----------------

    // Selection flag; a rising chip select abandons the frame.
    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            started_ff <= 1'b0;
        end else if (spi_hold_n_i) begin
            started_ff <= 1'b1;
        end
    end

    // Bit counter restarts at one on the first edge of a frame and saturates.
    always_comb begin
        if (!started_ff) begin
            nxt_bit_cnt = 12'h001;
        end else if (bit_cnt_ff == BITS_MAX) begin
            nxt_bit_cnt = BITS_MAX;
        end else begin
            nxt_bit_cnt = bit_cnt_ff + 12'h001;
        end
    end

    // Shift in MSB first and capture opcode, status byte and address.
    always_ff @(posedge spi_sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
            opcode_ff  <= '0;
            sr_data_ff <= '0;
            addr_ff    <= '0;
        end else if (spi_hold_n_i) begin
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff   <= {shift_ff[30:0], spi_si_i};
            if (nxt_bit_cnt == BITS_OPCODE) begin
                opcode_ff <= {shift_ff[6:0], spi_si_i};
            end
            if (nxt_bit_cnt == BITS_STATUS) begin
                sr_data_ff <= {shift_ff[6:0], spi_si_i};
            end
            if (nxt_bit_cnt == BITS_ADDR_CMD) begin
                addr_ff <= {shift_ff[22:0], spi_si_i};
            end
        end
    end

    // Busy level brought into the link domain.
    always_ff @(posedge spi_sck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_meta_ff <= 1'b0;
            busy_s_ff    <= 1'b0;
        end else begin
            busy_meta_ff <= (state_ff == ST_BUSY);
            busy_s_ff    <= busy_meta_ff;
        end
    end

    // Array read recognition once the command bytes are complete.
    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            read_active_ff <= 1'b0;
            read_fast_ff   <= 1'b0;
        end else if (spi_hold_n_i && started_ff && !busy_s_ff) begin
            if (nxt_bit_cnt == BITS_ADDR_CMD &&
                (opcode_ff == OP_READ || opcode_ff == OP_OTP_RD)) begin
                read_active_ff <= 1'b1;
            end
            if (nxt_bit_cnt == BITS_FAST_CMD && opcode_ff == OP_FAST_READ) begin
                read_active_ff <= 1'b1;
                read_fast_ff   <= 1'b1;
            end
        end
    end

    // Identification stream selection by opcode and byte index.
    always_comb begin
        id_byte = MAKER_CODE;
        id_last = 2'h0;
        emit    = 1'b0;
        if (started_ff && !busy_s_ff) begin
            if (opcode_ff == OP_STD_ID && bit_cnt_ff >= BITS_OPCODE) begin
                emit    = 1'b1;
                id_last = 2'h2;
                if (out_byte_ff == 2'h1) begin
                    id_byte = DEV_CODE1;
                end else if (out_byte_ff == 2'h2) begin
                    id_byte = DEV_CODE2;
                end
            end else if (opcode_ff == OP_LEGACY_SIG && bit_cnt_ff >= BITS_ADDR_CMD) begin
                emit    = 1'b1;
                id_byte = LEGACY_CODE;
            end else if (opcode_ff == OP_MAKER_DEV && bit_cnt_ff >= BITS_ADDR_CMD) begin
                emit    = 1'b1;
                id_last = 2'h1;
                if (addr_ff[0] ^ out_byte_ff[0]) begin
                    id_byte = DEV_CODE1;
                end
            end
        end
    end

    // Output shifter on falling edges, MSB first, wrapping over the byte list.
    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            out_pos_ff  <= 3'h0;
            out_byte_ff <= 2'h0;
            so_ff       <= 1'b0;
            so_en_ff    <= 1'b0;
        end else if (spi_hold_n_i) begin
            so_en_ff <= emit;
            if (emit) begin
                so_ff      <= id_byte[3'h7 - out_pos_ff];
                out_pos_ff <= out_pos_ff + 3'h1;
                if (out_pos_ff == 3'h7) begin
                    out_byte_ff <= (out_byte_ff == id_last) ? 2'h0
                                                            : out_byte_ff + 2'h1;
                end
            end
        end
    end

    // Output floats while paused or deselected.
    assign spi_so_o      = so_ff;
    assign spi_so_oe_o   = so_en_ff && spi_hold_n_i && !spi_cs_n_i;
    assign read_active_o = read_active_ff;
    assign read_fast_o   = read_fast_ff;

    // ---------------- System clock domain ----------------

    // Chip select and protect pin synchronisers.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
            wp_meta_ff <= 1'b1;
            wp_sync_ff <= 1'b1;
        end else begin
            cs_meta_ff <= spi_cs_n_i;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
            wp_meta_ff <= spi_wp_n_i;
            wp_sync_ff <= wp_meta_ff;
        end
    end

    // End of frame; link registers are quiet because the link clock has stopped.
    assign cs_rise = cs_sync_ff && !cs_prev_ff;
    assign locked  = sr_lock_ff && !wp_sync_ff;
    assign whole   = (bit_cnt_ff[2:0] == 3'h0);

    // Map write opcodes to array operation kinds.
    always_comb begin
        kind    = SFCFE_OP_PAGE;
        kind_ok = 1'b1;
        case (opcode_ff)
            OP_PAGE_WR:    kind = SFCFE_OP_PAGE;
            OP_PAGE_WR4:   kind = SFCFE_OP_PAGE4;
            OP_OTP_WR:     kind = SFCFE_OP_OTP;
            OP_SMALL_ER_A: kind = SFCFE_OP_SMALL_ER;
            OP_SMALL_ER_B: kind = SFCFE_OP_SMALL_ER;
            OP_LARGE_ER:   kind = SFCFE_OP_LARGE_ER;
            OP_FULL_ER_A:  kind = SFCFE_OP_FULL_ER;
            OP_FULL_ER_B:  kind = SFCFE_OP_FULL_ER;
            default:       kind_ok = 1'b0;
        endcase
    end

    // Decode a finished frame according to the current state.
    always_comb begin
        do_wel_set  = 1'b0;
        do_wel_clr  = 1'b0;
        do_sr_write = 1'b0;
        do_start    = 1'b0;
        do_wake     = 1'b0;
        do_susp     = 1'b0;
        do_resume   = 1'b0;
        if (cs_rise && bit_cnt_ff >= BITS_OPCODE) begin
            case (state_ff)
                ST_IDLE: begin
                    if (opcode_ff == OP_LATCH_SET && bit_cnt_ff == BITS_OPCODE) begin
                        do_wel_set = 1'b1;
                    end else if (opcode_ff == OP_LATCH_CLR && bit_cnt_ff == BITS_OPCODE) begin
                        do_wel_clr = 1'b1;
                    end else if (opcode_ff == OP_STATUS_WR && whole && wel_ff &&
                                 bit_cnt_ff >= BITS_STATUS && !locked) begin
                        do_sr_write = 1'b1;
                    end else if (kind_ok && kind != SFCFE_OP_FULL_ER && whole && wel_ff &&
                                 bit_cnt_ff >= BITS_ADDR_CMD && !area_protected_i) begin
                        do_start = 1'b1;
                    end else if (kind_ok && kind == SFCFE_OP_FULL_ER && whole && wel_ff &&
                                 bp_ff == 4'h0) begin
                        do_start = 1'b1;
                    end else if (opcode_ff == OP_LEGACY_SIG && bit_cnt_ff == BITS_OPCODE) begin
                        do_wake = 1'b1;
                    end
                end
                ST_BUSY: begin
                    if ((opcode_ff == OP_SUSP_A || opcode_ff == OP_SUSP_B) &&
                        bit_cnt_ff == BITS_OPCODE) begin
                        do_susp = 1'b1;
                    end
                end
                ST_SUSP: begin
                    if ((opcode_ff == OP_RESUME_A || opcode_ff == OP_RESUME_B) &&
                        bit_cnt_ff == BITS_OPCODE) begin
                        do_resume = 1'b1;
                    end
                end
                default: begin
                    do_wake = 1'b0;
                end
            endcase
        end
    end

    // Operating state and wake delay counter.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_ff    <= ST_IDLE;
            wake_cnt_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (do_start || do_resume) begin
                        state_ff <= ST_BUSY;
                    end else if (do_wake) begin
                        state_ff    <= ST_WAKE;
                        wake_cnt_ff <= WAKE_LOAD;
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt_ff == 8'h00) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        wake_cnt_ff <= wake_cnt_ff - 8'h01;
                    end
                end
                ST_BUSY: begin
                    if (op_done_i) begin
                        state_ff <= ST_IDLE;
                    end else if (do_susp) begin
                        state_ff <= ST_SUSP;
                    end
                end
                ST_SUSP: begin
                    if (do_resume) begin
                        state_ff <= ST_BUSY;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Write enable latch.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wel_ff <= 1'b0;
        end else if (do_wel_set) begin
            wel_ff <= 1'b1;
        end else if (do_wel_clr || do_sr_write || (state_ff == ST_BUSY && op_done_i)) begin
            wel_ff <= 1'b0;
        end
    end

    // Protection and quad enable bits of the status byte.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sr_lock_ff <= SR_RESET[SR_LOCK];
            quad_ff    <= SR_RESET[SR_QUAD];
            bp_ff      <= SR_RESET[SR_BP_HI:SR_BP_LO];
        end else if (do_sr_write) begin
            sr_lock_ff <= sr_data_ff[SR_LOCK];
            quad_ff    <= sr_data_ff[SR_QUAD];
            bp_ff      <= sr_data_ff[SR_BP_HI:SR_BP_LO];
        end
    end

    // Requests to the array engine.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            op_start_ff <= 1'b0;
            op_kind_ff  <= SFCFE_OP_PAGE;
            op_addr_ff  <= '0;
            suspend_ff  <= 1'b0;
            resume_ff   <= 1'b0;
        end else begin
            op_start_ff <= do_start;
            suspend_ff  <= do_susp;
            resume_ff   <= do_resume;
            if (do_start) begin
                op_kind_ff <= kind;
                op_addr_ff <= addr_ff;
            end
        end
    end

    assign op_start_o = op_start_ff;
    assign op_kind_o  = op_kind_ff;
    assign op_addr_o  = op_addr_ff;
    assign suspend_o  = suspend_ff;
    assign resume_o   = resume_ff;
    assign status_o   = {sr_lock_ff, quad_ff, bp_ff, wel_ff, state_ff == ST_BUSY};

    // Checks of the write gating and decoder.
    a_wel_gate: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        op_start_o |-> $past(wel_ff))
        else $error("Operation started with the latch clear.");

    a_whole_bytes: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        op_start_o |-> ($past(bit_cnt_ff[2:0]) == 3'h0))
        else $error("Operation started from a partial byte.");

    a_status_lock: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        locked |=> $stable({sr_lock_ff, quad_ff, bp_ff}))
        else $error("Locked status bits changed.");

    a_full_erase_bp: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (op_start_o && op_kind_o == SFCFE_OP_FULL_ER) |-> (bp_ff == 4'h0))
        else $error("Chip erase started with protect bits set.");

    a_area_refuse: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (op_start_o && op_kind_o != SFCFE_OP_FULL_ER) |-> !$past(area_protected_i))
        else $error("Operation started on a protected area.");

    a_wel_autoclear: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (state_ff == ST_BUSY && op_done_i) |=> (!wel_ff && state_ff == ST_IDLE))
        else $error("Latch not cleared at completion.");

    a_wake_quiet: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        do_wake |=> (state_ff == ST_WAKE && !op_start_o)[*8])
        else $error("Instruction accepted during wake delay.");

    a_busy_ignore: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (cs_rise && state_ff == ST_BUSY && !op_done_i && opcode_ff == OP_LEGACY_SIG)
        |=> (state_ff == ST_BUSY))
        else $error("Release opcode disturbed a running operation.");

    a_wel_reset: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> !wel_ff)
        else $error("Latch set right after reset.");

    a_opcode_load: assert property (
        @(posedge spi_sck_i) disable iff (!resetn_i)
        (started_ff && spi_hold_n_i && bit_cnt_ff == 12'h007)
        |=> (opcode_ff == {$past(shift_ff[6:0]), $past(spi_si_i)}))
        else $error("Opcode not captured at the eighth bit.");

    c_array_start: cover property (@(posedge clk_i) disable iff (!resetn_i) op_start_o);
    c_wake_seen:   cover property (@(posedge clk_i) disable iff (!resetn_i) do_wake);
    c_suspend:     cover property (@(posedge clk_i) disable iff (!resetn_i) suspend_o);
    c_id_stream:   cover property (@(negedge spi_sck_i) disable iff (!resetn_i)
                                   so_en_ff && out_byte_ff == 2'h2);

endmodule

/* File: sfcfe_pkg.sv */
// Constants and types shared by the serial flash command front end.
package sfcfe_pkg;

    // Instruction opcodes.
    localparam logic [7:0] OP_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR   = 8'h04;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0b;
    localparam logic [7:0] OP_PAGE_WR     = 8'h02;
    localparam logic [7:0] OP_PAGE_WR4    = 8'h32;
    localparam logic [7:0] OP_SMALL_ER_A  = 8'hd7;
    localparam logic [7:0] OP_SMALL_ER_B  = 8'h20;
    localparam logic [7:0] OP_LARGE_ER    = 8'hd8;
    localparam logic [7:0] OP_FULL_ER_A   = 8'hc7;
    localparam logic [7:0] OP_FULL_ER_B   = 8'h60;
    localparam logic [7:0] OP_SUSP_A      = 8'h75;
    localparam logic [7:0] OP_SUSP_B      = 8'hb0;
    localparam logic [7:0] OP_RESUME_A    = 8'h7a;
    localparam logic [7:0] OP_RESUME_B    = 8'h30;
    localparam logic [7:0] OP_OTP_WR      = 8'hb1;
    localparam logic [7:0] OP_OTP_RD      = 8'h4b;
    localparam logic [7:0] OP_MAKER_DEV   = 8'h90;
    localparam logic [7:0] OP_STD_ID      = 8'h9f;
    localparam logic [7:0] OP_LEGACY_SIG  = 8'hab;

    // Bit counts that mark the end of command phases.
    localparam int         CNT_W          = 12;
    localparam logic [11:0] BITS_OPCODE   = 12'h008;
    localparam logic [11:0] BITS_STATUS   = 12'h010;
    localparam logic [11:0] BITS_ADDR_CMD = 12'h020;
    localparam logic [11:0] BITS_FAST_CMD = 12'h028;
    localparam logic [11:0] BITS_MAX      = 12'hfff;

    // Status byte layout and reset value.
    localparam int         SR_LOCK        = 7;
    localparam int         SR_QUAD        = 6;
    localparam int         SR_BP_HI       = 5;
    localparam int         SR_BP_LO       = 2;
    localparam int         SR_WEL         = 1;
    localparam int         SR_WIP         = 0;
    localparam logic [7:0] SR_RESET       = 8'h00;

    // Wake delay after release from power-down.
    localparam int         CLK_PERIOD_NS  = 20;
    localparam int         WAKE_DELAY_NS  = 3000;
    localparam int         WAKE_CYCLES    = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WAKE_LOAD      = 8'(WAKE_CYCLES - 1);

    // Kinds of array operation handed to the array engine.
    typedef enum logic [2:0] {
        SFCFE_OP_PAGE,
        SFCFE_OP_PAGE4,
        SFCFE_OP_OTP,
        SFCFE_OP_SMALL_ER,
        SFCFE_OP_LARGE_ER,
        SFCFE_OP_FULL_ER
    } sfcfe_op_t;

    // Operating states of the command front end.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAKE,
        ST_BUSY,
        ST_SUSP
    } sfcfe_state_t;

endpackage

/* File: sfcfe_master.sv */
// Serial link master model that shifts whole frames into the front end.
`timescale 1ns/1ns
module sfcfe_master (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    output logic      hold_n_o,
    input  wire logic so_i
);
    // The link idles deselected, with its clock held low and no pause.
    // A short select pulse at start gives the link flops a clean deselect edge.
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b0;
        si_o = 1'b0;
        hold_n_o = 1'b1;
        #1 cs_n_o = 1'b1;
    end
    // Shifts n bits MSB first while the clock is low, pausing before bit p, then deselects.
    task automatic xfer(input logic [63:0] d, input int n, output logic [63:0] q, input int p = -1);
        q = '0;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            if (i == p) begin
                #8 hold_n_o = 1'b0;
                repeat (4) begin
                    #8 si_o = ~si_o;  // Noise that the paused front end must ignore.
                    #8 sck_o = 1'b1;
                    #16 sck_o = 1'b0;
                end
                #8 hold_n_o = 1'b1;
            end
            si_o = d[i];
            #16 sck_o = 1'b1;
            q = {q[62:0], so_i};
            #16 sck_o = 1'b0;
        end
        cs_n_o = 1'b1;
        si_o = ~si_o;  // Released data no longer shows the last bit.
        #200;
    endtask
endmodule

/* File: serial_flash_command_front_end_test.sv */
// Self-checking bench for the serial flash command front end.
`timescale 1ns/1ns
module serial_flash_command_front_end_test;
    import sfcfe_pkg::*;
    logic clk_i, resetn_i, op_done_i, area_protected_i, spi_wp_n_i, spi_sck_i, spi_cs_n_i;
    logic spi_si_i, spi_hold_n_i, spi_so_o, spi_so_oe_o, op_start_o, suspend_o, resume_o;
    logic read_active_o, read_fast_o;
    logic [2:0]  rd;
    logic [23:0] op_addr_o, addr;
    logic [7:0]  status_o;
    logic [63:0] q;
    sfcfe_op_t   op_kind_o;
    int          errors, compares, cyc, starts, susp, resm, exp_starts;
    logic [7:0]  ops [8] = '{8'h02, 8'h32, 8'hd7, 8'h20, 8'hd8, 8'hb1, 8'hc7, 8'h60};
    logic [7:0]  sus [2] = '{8'h75, 8'hb0};
    logic [7:0]  res [2] = '{8'h7a, 8'h30};
    sfcfe_op_t   kinds [8] = '{SFCFE_OP_PAGE, SFCFE_OP_PAGE4, SFCFE_OP_SMALL_ER,
        SFCFE_OP_SMALL_ER, SFCFE_OP_LARGE_ER, SFCFE_OP_OTP, SFCFE_OP_FULL_ER, SFCFE_OP_FULL_ER};
    sfcfe_core i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .spi_sck_i(spi_sck_i),
        .spi_cs_n_i(spi_cs_n_i), .spi_si_i(spi_si_i), .spi_hold_n_i(spi_hold_n_i),
        .spi_wp_n_i(spi_wp_n_i), .spi_so_o(spi_so_o), .spi_so_oe_o(spi_so_oe_o),
        .read_active_o(read_active_o), .read_fast_o(read_fast_o), .op_start_o(op_start_o),
        .op_kind_o(op_kind_o),
        .op_addr_o(op_addr_o), .op_done_i(op_done_i), .area_protected_i(area_protected_i),
        .suspend_o(suspend_o), .resume_o(resume_o), .status_o(status_o));
    sfcfe_master i_mst (.sck_o(spi_sck_i), .cs_n_o(spi_cs_n_i), .si_o(spi_si_i),
        .hold_n_o(spi_hold_n_i), .so_i(spi_so_o));
    // Prints the verdict and ends the run.
    task automatic final_report;
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares one result with its expected value.
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Pulses the array engine's completion for one cycle.
    task automatic done;
        @(posedge clk_i) #2 op_done_i = 1'b1;
        @(posedge clk_i) #2 op_done_i = 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // The clock runs at 50 MHz.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Counts the design's pulses and cuts a hang short.
    always @(posedge clk_i) begin
        cyc++;
        starts += int'(op_start_o === 1'b1);
        susp += int'(suspend_o === 1'b1);
        resm += int'(resume_o === 1'b1);
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    // Read flags and output enable as seen at each link clock rise.
    always @(posedge spi_sck_i) begin
        rd = {read_active_o, read_fast_o, spi_so_oe_o};
    end
    // Main sequence: refusals, every write command, suspend, then identification reads.
    initial begin
        resetn_i = 1'b1;
        op_done_i = 1'b0;
        area_protected_i = 1'b0;
        spi_wp_n_i = 1'b1;
        #1 resetn_i = 1'b0;  // A clean falling edge clears the link flops.
        q = 64'($urandom(32'h4d60));
        repeat (2) @(posedge clk_i);
        #2 resetn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        cmp(status_o, SR_RESET);
        i_mst.xfer({8'h02, 24'h0}, 32, q);
        cmp(starts, 0);
        i_mst.xfer(64'h06, 8, q);
        cmp(status_o[1], 1'b1);
        i_mst.xfer({8'h02, 25'h0}, 33, q);
        @(posedge clk_i) #2 area_protected_i = 1'b1;
        i_mst.xfer({8'h20, 24'h0}, 32, q);
        cmp({starts, 7'h0, status_o[1]}, 40'h1);
        @(posedge clk_i) #2 area_protected_i = 1'b0;
        for (int i = 0; i < 8; i++) begin
            addr = 24'($urandom);
            if (i > 0) i_mst.xfer(64'h06, 8, q);
            i_mst.xfer({ops[i], addr}, 32, q);
            exp_starts++;
            cmp(starts, exp_starts);
            cmp(op_kind_o, kinds[i]);
            if (i < 6) cmp(op_addr_o, addr);
            if (i == 2) i_mst.xfer(64'hab, 8, q);
            cmp(status_o[1:0], 2'b11);
            if (i < 2) begin
                i_mst.xfer(sus[i], 8, q);
                i_mst.xfer(res[i], 8, q);
                cmp({susp, resm}, {i + 1, i + 1});
            end
            done();
            cmp(status_o[1:0], 2'b00);
        end
        i_mst.xfer(64'hab, 8, q);
        i_mst.xfer(64'h06, 8, q);
        cmp(status_o[1], 1'b0);
        repeat (WAKE_CYCLES) @(posedge clk_i);
        i_mst.xfer(64'h06, 8, q);
        i_mst.xfer(16'h0180, 16, q);
        cmp(status_o, 8'h80);
        @(posedge clk_i) #2 spi_wp_n_i = 1'b0;
        i_mst.xfer(64'h06, 8, q);
        i_mst.xfer(16'h0100, 16, q);
        cmp(status_o, 8'h82);
        @(posedge clk_i) #2 spi_wp_n_i = 1'b1;
        i_mst.xfer(16'h013c, 16, q);
        i_mst.xfer(64'h06, 8, q);
        i_mst.xfer(64'hc7, 8, q);
        cmp({starts, status_o}, {exp_starts, 8'h3e});
        i_mst.xfer(64'h04, 8, q);
        cmp(status_o, 8'h3c);
        i_mst.xfer({8'h03, 24'($urandom), 8'h0}, 40, q);
        cmp(rd, 3'b100);
        i_mst.xfer({8'h0b, 40'($urandom)}, 48, q);
        cmp(rd, 3'b110);
        i_mst.xfer({8'h90, 24'h000001, 16'h0}, 48, q);
        cmp(q[15:0], 16'h3ca5);
        i_mst.xfer(64'h9f << 48, 56, q, 52);
        cmp(q[47:0], 48'ha53c5ea53c5e);
        cmp(rd[0], 1'b1);
        i_mst.xfer(64'hab << 40, 48, q);
        cmp(q[15:0], 16'h2d2d);
        final_report();
    end
endmodule
